// file: pkg/boundary_scan_tap_regs.vh
// Constants of the boundary scan test port
`ifndef BOUNDARY_SCAN_TAP_REGS_VH
`define BOUNDARY_SCAN_TAP_REGS_VH
`define OPC_W 3
`define OPC_EXTEST 3'h0
`define OPC_IDCODE 3'h1
`define OPC_SAMPLE_Z 3'h2
`define OPC_SAMPLE_PRELOAD 3'h4
`define OPC_BYPASS 3'h7
`define OPC_CAPTURE_PAT 2'h1
`define SIG_W 32
`define RING_W 109
`define RING_OE_BIT 108
`define VER_MSB 29'd31
`define VER_LSB 29
`define PART_LSB 12
`define MAKER_LSB 1
`define RESET_TMS_EDGES 5
`define ST_W 4
`define ST_RESET 4'h0
`define ST_IDLE 4'h1
`define ST_SEL_DR 4'h2
`define ST_CAP_DR 4'h3
`define ST_SHIFT_DR 4'h4
`define ST_EXIT1_DR 4'h5
`define ST_PAUSE_DR 4'h6
`define ST_EXIT2_DR 4'h7
`define ST_UPD_DR 4'h8
`define ST_SEL_IR 4'h9
`define ST_CAP_IR 4'ha
`define ST_SHIFT_IR 4'hb
`define ST_EXIT1_IR 4'hc
`define ST_PAUSE_IR 4'hd
`define ST_EXIT2_IR 4'he
`define ST_UPD_IR 4'hf
`endif

// file: core/tap_state_step.v
// Next-state logic of the sixteen-state test port controller
`timescale 1ns/1ns
`default_nettype none
`include "boundary_scan_tap_regs.vh"
module tap_state_step (
    input wire [`ST_W-1:0] state,
    input wire tms,
    output reg [`ST_W-1:0] next_state
);
    always @* begin
        case (state)
            `ST_RESET: next_state = tms ? `ST_RESET : `ST_IDLE;
            `ST_IDLE: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_DR: next_state = tms ? `ST_SEL_IR : `ST_CAP_DR;
            `ST_CAP_DR: next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_SHIFT_DR: next_state = tms ? `ST_EXIT1_DR : `ST_SHIFT_DR;
            `ST_EXIT1_DR: next_state = tms ? `ST_UPD_DR : `ST_PAUSE_DR;
            `ST_PAUSE_DR: next_state = tms ? `ST_EXIT2_DR : `ST_PAUSE_DR;
            `ST_EXIT2_DR: next_state = tms ? `ST_UPD_DR : `ST_SHIFT_DR;
            `ST_UPD_DR: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
            `ST_SEL_IR: next_state = tms ? `ST_RESET : `ST_CAP_IR;
            `ST_CAP_IR: next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_SHIFT_IR: next_state = tms ? `ST_EXIT1_IR : `ST_SHIFT_IR;
            `ST_EXIT1_IR: next_state = tms ? `ST_UPD_IR : `ST_PAUSE_IR;
            `ST_PAUSE_IR: next_state = tms ? `ST_EXIT2_IR : `ST_PAUSE_IR;
            `ST_EXIT2_IR: next_state = tms ? `ST_UPD_IR : `ST_SHIFT_IR;
            `ST_UPD_IR: next_state = tms ? `ST_SEL_DR : `ST_IDLE;
            default: next_state = `ST_RESET;
        endcase
    end
endmodule // tap_state_step
`default_nettype wire

// file: core/boundary_scan_tap.v
// Boundary scan test access port sampled on the system clock
`timescale 1ns/1ns
`default_nettype none
`include "boundary_scan_tap_regs.vh"
module boundary_scan_tap #(
    // Arbitrary neutral identity values
    parameter [2:0] VERSION_CODE = 3'h1,
    parameter [16:0] PART_CODE = 17'h0_1234,
    parameter [10:0] MAKER_CODE = 11'h055
) (
    input wire clk,
    input wire rstn,
    input wire tck,
    input wire tms,
    input wire tdi,
    output reg tdo,
    output reg tdo_oe,
    input wire [`RING_W-1:0] pin_ring_in,
    output reg [`RING_W-1:0] pin_ring_out,
    output reg extest_drive,
    output reg mem_out_hiz,
    output reg [`OPC_W-1:0] active_opcode,
    output reg [`ST_W-1:0] tap_state
);
    localparam [`SIG_W-1:0] SIGNATURE =
        {VERSION_CODE, PART_CODE, MAKER_CODE, 1'b1};

    reg [2:0] tck_sync;
    reg [1:0] tms_sync;
    reg [1:0] tdi_sync;
    wire tck_rise;
    wire tck_fall;
    wire tms_s;
    wire tdi_s;
    wire [`ST_W-1:0] next_state;
    reg [`OPC_W-1:0] opcode_shift_reg;
    reg single_bit_skip_reg;
    reg [`SIG_W-1:0] chip_signature_word;
    reg [`RING_W-1:0] pin_ring_chain;
    reg serial_bit;
    reg [`RING_W-1:0] ring_sample;
    reg [`RING_W-1:0] ring_meta;

    // Edges seen after two sampling stages; the test clock must stay
    // high and low for at least three system clocks each
    assign tck_rise = tck_sync[1] & ~tck_sync[2];
    assign tck_fall = ~tck_sync[1] & tck_sync[2];
    assign tms_s = tms_sync[1];
    assign tdi_s = tdi_sync[1];

    function is_ring_opcode;
        input [`OPC_W-1:0] op;
        begin
            is_ring_opcode = (op == `OPC_EXTEST) || (op == `OPC_SAMPLE_Z) ||
                (op == `OPC_SAMPLE_PRELOAD);
        end
    endfunction

    function is_ident_opcode;
        input [`OPC_W-1:0] op;
        begin
            is_ident_opcode = (op == `OPC_IDCODE);
        end
    endfunction

    tap_state_step u_step (
        .state(tap_state),
        .tms(tms_s),
        .next_state(next_state)
    );

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tck_sync <= 3'h0;
            tms_sync <= 2'h3;
            tdi_sync <= 2'h3;
            ring_meta <= {`RING_W{1'b0}};
            ring_sample <= {`RING_W{1'b0}};
        end else begin
            tck_sync <= {tck_sync[1:0], tck};
            tms_sync <= {tms_sync[0], tms};
            tdi_sync <= {tdi_sync[0], tdi};
            ring_meta <= pin_ring_in;
            ring_sample <= ring_meta;
        end
    end

    // Controller, shift paths and update stages
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tap_state <= `ST_RESET;
            active_opcode <= `OPC_IDCODE;
            opcode_shift_reg <= `OPC_IDCODE;
            single_bit_skip_reg <= 1'b0;
            chip_signature_word <= {`SIG_W{1'b0}};
            pin_ring_chain <= {`RING_W{1'b0}};
            pin_ring_out <= {`RING_W{1'b0}};
        end else if (tck_rise) begin
            tap_state <= next_state;
            case (tap_state)
                `ST_CAP_IR: begin
                    opcode_shift_reg <= {active_opcode[`OPC_W-1], `OPC_CAPTURE_PAT};
                end
                `ST_SHIFT_IR: begin
                    opcode_shift_reg <= {tdi_s, opcode_shift_reg[`OPC_W-1:1]};
                end
                `ST_UPD_IR: begin
                    active_opcode <= opcode_shift_reg;
                end
                `ST_CAP_DR: begin
                    if (is_ident_opcode(active_opcode)) begin
                        chip_signature_word <= SIGNATURE;
                    end else if (is_ring_opcode(active_opcode)) begin
                        pin_ring_chain <= ring_sample;
                    end else begin
                        single_bit_skip_reg <= 1'b0;
                    end
                end
                `ST_SHIFT_DR: begin
                    if (is_ident_opcode(active_opcode)) begin
                        chip_signature_word <= {tdi_s, chip_signature_word[`SIG_W-1:1]};
                    end else if (is_ring_opcode(active_opcode)) begin
                        pin_ring_chain <= {tdi_s, pin_ring_chain[`RING_W-1:1]};
                    end else begin
                        single_bit_skip_reg <= tdi_s;
                    end
                end
                `ST_UPD_DR: begin
                    if (is_ring_opcode(active_opcode)) begin
                        pin_ring_out <= pin_ring_chain;
                    end
                end
                default: begin
                end
            endcase
            // Entering the reset state restores the identify opcode at once
            if (next_state == `ST_RESET) begin
                active_opcode <= `OPC_IDCODE;
                pin_ring_out <= {`RING_W{1'b0}};
            end
        end
    end

    // Selected serial bit, presented on the falling edge
    always @* begin
        serial_bit = single_bit_skip_reg;
        if (tap_state == `ST_SHIFT_IR) begin
            serial_bit = opcode_shift_reg[0];
        end else if (is_ident_opcode(active_opcode)) begin
            serial_bit = chip_signature_word[0];
        end else if (is_ring_opcode(active_opcode)) begin
            serial_bit = pin_ring_chain[0];
        end
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            tdo <= 1'b0;
            tdo_oe <= 1'b0;
        end else if (tck_fall) begin
            tdo <= serial_bit;
            tdo_oe <= (tap_state == `ST_SHIFT_IR) || (tap_state == `ST_SHIFT_DR);
        end
    end

    // Output control levels follow the opcode in force
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            mem_out_hiz <= 1'b0;
            extest_drive <= 1'b0;
        end else begin
            mem_out_hiz <= (active_opcode == `OPC_SAMPLE_Z) ||
                ((active_opcode == `OPC_EXTEST) && !pin_ring_out[`RING_OE_BIT]);
            extest_drive <= (active_opcode == `OPC_EXTEST);
        end
    end
endmodule // boundary_scan_tap
`default_nettype wire

// file: test/scan_host.sv
// Test controller model driving the scan pins
`timescale 1ns/1ns
`default_nettype none
module scan_host (
    output logic tck,
    output logic tms,
    output logic tdi,
    input wire logic tdo
);
    initial begin
        tck = 1'b0;
        tms = 1'b1;
        tdi = 1'b0;
    end
    // One test clock period; tck rests low between calls
    task step(input logic m, input logic d, output logic q);
        tms = m;
        tdi = d;
        #400 tck = 1'b1;
        #200 tdi = ~d;
        #199 q = tdo;
        #1 tck = 1'b0;
    endtask
endmodule // scan_host
`default_nettype wire

// file: test/tap_checker_properties.sv
// Checker of the boundary scan test port outputs
`timescale 1ns/1ns
`default_nettype none
`include "boundary_scan_tap_regs.vh"
module tap_checker (
    input wire logic clk,
    input wire logic rstn,
    input wire logic tck,
    input wire logic tdo,
    input wire logic [`RING_W-1:0] pin_ring_out,
    input wire logic extest_drive,
    input wire logic mem_out_hiz,
    input wire logic [`OPC_W-1:0] active_opcode,
    input wire logic [`ST_W-1:0] tap_state
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rstn);
    property p_ext; (active_opcode == `OPC_EXTEST && $stable(pin_ring_out))[*2]
        |-> extest_drive && mem_out_hiz != pin_ring_out[`RING_OE_BIT]; endproperty
    a_ext: assert property (p_ext) else $error("extest control wrong");
    property p_hiz; (active_opcode == `OPC_SAMPLE_Z)[*2]
        |-> mem_out_hiz && !extest_drive; endproperty
    a_hiz: assert property (p_hiz) else $error("outputs not floated");
    property p_quiet; (active_opcode inside {`OPC_IDCODE, `OPC_SAMPLE_PRELOAD, `OPC_BYPASS})[*2]
        |-> !mem_out_hiz && !extest_drive; endproperty
    a_quiet: assert property (p_quiet) else $error("memory disturbed");
    property p_idle; (tap_state == `ST_RESET)[*3]
        |-> active_opcode == `OPC_IDCODE && pin_ring_out == 0; endproperty
    a_idle: assert property (p_idle) else $error("reset state opcode wrong");
    property p_tdo; $changed(tdo) |-> !$past(tck, 2); endproperty
    a_tdo: assert property (p_tdo) else $error("tdo moved off falling edge");
    property p_upd; $changed(tap_state) && $past(tap_state) == `ST_UPD_DR
        |-> tap_state inside {`ST_IDLE, `ST_SEL_DR}; endproperty
    a_upd: assert property (p_upd) else $error("bad step after update");
    property p_opc; $changed(active_opcode) |-> tap_state == `ST_RESET
        || $past(tap_state) inside {`ST_UPD_IR, `ST_RESET}
        || $past(tap_state, 2) inside {`ST_UPD_IR, `ST_RESET}; endproperty
    a_opc: assert property (p_opc) else $error("opcode changed outside update");
    property p_cap; $changed(tap_state) && $past(tap_state) == `ST_CAP_IR
        |-> tap_state inside {`ST_SHIFT_IR, `ST_EXIT1_IR}; endproperty
    a_cap: assert property (p_cap) else $error("bad step after capture");
endmodule // tap_checker
bind boundary_scan_tap tap_checker tap_checker_i (.clk(clk), .rstn(rstn), .tck(tck), .tdo(tdo),
    .pin_ring_out(pin_ring_out), .extest_drive(extest_drive), .mem_out_hiz(mem_out_hiz),
    .active_opcode(active_opcode), .tap_state(tap_state));
`default_nettype wire

// file: test/testbench.sv
// Bench for the boundary scan test port
`timescale 1ns/1ns
`default_nettype none
`include "boundary_scan_tap_regs.vh"
module testbench;
    localparam [31:0] SIG = 32'ha5c3_2563; // Arbitrary identity, bit 0 set
    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic q;
    logic shift_oe;
    logic [`RING_W-1:0] ring_in = '0;
    logic [`RING_W-1:0] got;
    wire tck, tms, tdi, tdo, oe, ext, hiz;
    wire [`RING_W-1:0] ring_out;
    wire [`OPC_W-1:0] opc;
    wire [`ST_W-1:0] st;
    int num_errors = 0;
    int compares = 0;
    always #50 clk = ~clk;
    boundary_scan_tap #(.VERSION_CODE(SIG[31:29]), .PART_CODE(SIG[28:12]),
        .MAKER_CODE(SIG[11:1])) boundary_scan_tap_i (.clk(clk), .rstn(rstn), .tck(tck),
        .tms(tms), .tdi(tdi), .tdo(tdo), .tdo_oe(oe), .pin_ring_in(ring_in),
        .pin_ring_out(ring_out), .extest_drive(ext), .mem_out_hiz(hiz),
        .active_opcode(opc), .tap_state(st));
    scan_host scan_host_i (.tck(tck), .tms(tms), .tdi(tdi), .tdo(tdo));
    task check(input string n, input logic [127:0] s, input logic [127:0] e);
        compares++;
        if (s !== e) begin
            num_errors++;
            $display("ERROR %s expected %h seen %h", n, e, s);
        end
    endtask
    // From idle through one data or instruction scan back to idle
    task scan(input logic ir, input int n, input logic [`RING_W-1:0] din);
        got = '0;
        shift_oe = 1'b1;
        repeat (int'(ir) + 1) scan_host_i.step(1'b1, 1'b0, q);
        repeat (2) scan_host_i.step(1'b0, 1'b0, q);
        for (int i = 0; i < n; i++) begin
            scan_host_i.step(i == n - 1, din[i], q);
            got[i] = q;
            shift_oe &= oe;
        end
        scan_host_i.step(1'b1, 1'b0, q);
        scan_host_i.step(1'b0, 1'b0, q);
        check("output enable", {shift_oe, oe}, 2'b10);
    endtask
    task test_idcode;
        scan(1'b0, 32, '1);
        check("signature", got, SIG);
    endtask
    task test_bypass;
        scan(1'b1, 3, `OPC_BYPASS);
        check("ir capture", got, 3'b001);
        scan(1'b0, 2, 2'b11);
        check("bypass", {opc, hiz, ext, got[1:0]}, {`OPC_BYPASS, 4'b0010});
    endtask
    task test_ring;
        logic [`OPC_W-1:0] op;
        logic [`RING_W-1:0] din;
        for (int k = 0; k < 3; k++) begin
            op = (k == 0) ? `OPC_SAMPLE_PRELOAD : (k == 1) ? `OPC_EXTEST : `OPC_SAMPLE_Z;
            din = {k == 0, {9{12'h5a3}}} ^ k;
            ring_in = {9{12'hc3f}} << k;
            scan(1'b1, 3, op);
            check("out control", {hiz, ext}, {op == `OPC_SAMPLE_Z, op == `OPC_EXTEST});
            scan(1'b0, `RING_W, din);
            check("ring capture", got, ring_in);
            check("ring update", ring_out, din);
        end
    endtask
    // Test reset taken in the middle of a shift
    task test_abort;
        scan_host_i.step(1'b1, 1'b0, q);
        repeat (3) scan_host_i.step(1'b0, 1'b1, q);
        repeat (5) scan_host_i.step(1'b1, 1'b0, q);
        check("tms reset", {st, opc, hiz, ring_out}, {`ST_RESET, `OPC_IDCODE, 110'h0});
    endtask
    task end_sim;
        $display("compares %0d num_errors %0d", compares, num_errors);
        if (num_errors == 0 && compares > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    initial begin
        repeat (5) @(negedge clk);
        rstn = 1'b1;
        check("power up", {st, opc}, {`ST_RESET, `OPC_IDCODE});
        repeat (3) @(negedge clk);
        scan_host_i.step(1'b0, 1'b0, q);
        test_idcode;
        test_bypass;
        test_ring;
        test_abort;
        end_sim;
    end
endmodule // testbench
`default_nettype wire
